// ---- core/sbe_defines.vh ----
// Shared widths, field positions and reset values for the system bus block
`ifndef SBE_DEFINES_VH
`define SBE_DEFINES_VH

`define SBE_AD_W 32
`define SBE_CMD_W 5
`define SBE_HI_W 4
`define SBE_CHK_W 4
`define SBE_TOUT_W 16
`define SBE_TOUT_RST 16'hFFFF
`define SBE_AD_ZERO 32'h0000_0000
`define SBE_HI_ZERO 4'h0
`define SBE_CHK_ZERO 4'h0

// Command bus bit 4 tells address cycle (0) from data cycle (1)
`define SBE_CMD_DATA 4
// Data identifier fields in command bits 3:0
`define SBE_ID_LAST 3
`define SBE_ID_RESP 2
`define SBE_ID_ERR 1
`define SBE_ID_NOCHK 0
// Identifier sent with processor write data: final, not response, good, checked
`define SBE_WR_ID 4'h4

`endif

// ---- core/sbe_rd_timeout.v ----
// Read reply timeout counter
`timescale 1ns/1ps
`include "sbe_defines.vh"
module sbe_rd_timeout #(
   parameter CW = `SBE_TOUT_W
) (
   input wire i_core_clk,           // System interface clock
   input wire i_reset,              // Async reset, active high
   input wire i_start,              // Read request issued
   input wire i_stop,               // Read reply complete
   input wire i_enable,             // Counter enable
   input wire i_native_mode,        // High: counter inoperative
   input wire [CW-1:0] i_period,    // Loaded period
   output reg o_expired             // One-cycle timeout pulse
);
   reg [CW-1:0] count;
   reg active;

   // Zero period fires at once whatever the enable, as the hardware does
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         count <= {CW{1'b0}};
         active <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         o_expired <= 1'b0;
         if (i_native_mode || i_stop) begin
            active <= 1'b0;
         end else if (i_start) begin
            count <= i_period;
            active <= 1'b1;
            if (i_period == {CW{1'b0}}) begin
               o_expired <= 1'b1;
               active <= 1'b0;
            end
         end else if (active && i_enable) begin
            count <= count - {{(CW-1){1'b0}}, 1'b1};
            if (count == {{(CW-1){1'b0}}, 1'b1}) begin
               o_expired <= 1'b1;
               active <= 1'b0;
            end
         end
      end
   end
endmodule // sbe_rd_timeout

// ---- core/sbe_sysif.v ----
// System interface handshake engine with read data error handling
`timescale 1ns/1ps
`include "sbe_defines.vh"

// Function
// - In native mode, a check-bit failure in checked read data raises bus error, any refill element.
// - Bad good-data flag raises bus error two cycles after data arrives.
// - Check-bit failure raises bus error three cycles after response data arrives.
// - Bus error during block refill marks the cache line invalid.
// - Good-data and check-bit errors look identical to software.
// - Protocol select low picks alternate handshake mode, high native mode.
// - Alternate mode offers no protocol-error flag.
// - Internal counter raises bus error when a read reply never arrives.
// - Timeout period 16 bits, default all ones, enable-gated unless zero, off when select high.
// - Alternate mode drives upper command, check bits and parity low.
// - Alternate mode drives read-ready line constantly low.
// - 32-bit shared address/data bus and 5-bit shared command bus.
// - Valid-out asserted only while driving valid address/data and command.
// - Mastership output low tells agent it may take the bus.
// - Command bus top bit marks address cycle low, data cycle high.
module sbe_sysif #(
   parameter CNT_W = 4
) (
   input wire i_core_clk,                          // System interface clock
   input wire i_reset,                             // Async reset, active high
   input wire i_protocol_select_pin,               // Strap, low = alternate mode
   input wire [`SBE_TOUT_W-1:0] i_read_timeout_period, // Timeout period, default all ones
   input wire i_read_timeout_enable,               // Timeout counter enable
   input wire i_req_valid,                         // Core request present
   input wire i_req_write,                         // 1 write, 0 read
   input wire [3:0] i_req_cmd,                     // Command for address cycle
   input wire [`SBE_AD_W-1:0] i_req_addr,          // Physical address
   input wire [`SBE_AD_W-1:0] i_req_wdata,         // Write data word
   input wire [CNT_W-1:0] i_req_words,             // Read words, 1 = single
   output reg o_req_ready,                         // Request taken this cycle
   output reg [`SBE_AD_W-1:0] o_rd_data,           // Read response word
   output reg o_rd_valid,                          // Read word pulse
   output reg o_rd_last,                           // Last word of reply
   output reg o_bus_error,                         // Bus error exception pulse
   output reg o_line_invalid,                      // Refill line to be invalidated
   input wire [`SBE_AD_W-1:0] i_sys_addr_data_bus, // Address/data pin in
   output reg [`SBE_AD_W-1:0] o_sys_addr_data_bus, // Address/data pin out
   output reg o_sys_addr_data_bus_oe,              // Address/data drive enable
   input wire [`SBE_CMD_W-1:0] i_sys_command_bus,  // Command pin in
   output reg [`SBE_CMD_W-1:0] o_sys_command_bus,  // Command pin out
   output reg o_sys_command_bus_oe,                // Command drive enable
   output reg [`SBE_HI_W-1:0] o_sys_command_hi,    // Upper command lines
   input wire [`SBE_CHK_W-1:0] i_data_check_bits,  // Check bits in (native)
   output reg [`SBE_CHK_W-1:0] o_data_check_bits,  // Check bits out
   output reg o_data_check_bits_oe,                // Check bits drive enable
   output reg o_command_parity,                    // Command parity line
   output reg o_read_ready_n,                      // Read-ready line out
   output reg o_read_ready_oe,                     // Read-ready drive enable
   input wire i_ext_valid_in_n,                    // Agent valid, low active
   output reg o_proc_valid_out_n,                  // Processor valid, low active
   input wire i_ext_bus_rqst_n,                    // Agent bus request, low active
   output reg o_proc_mastership_release_n,         // Bus released, low active
   input wire i_ext_accept_ready_n                 // Agent accept-ok, low active
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_WADDR = 5'b00010;
   localparam ST_WDATA = 5'b00100;
   localparam ST_RWAIT = 5'b01000;
   localparam ST_EXT = 5'b10000;

   reg mode_s1;
   reg mode_s2;
   reg in_valid_n;
   reg in_rqst_n;
   reg in_accept_n;
   reg [`SBE_CMD_W-1:0] in_cmd;
   reg [`SBE_AD_W-1:0] in_ad;
   reg [`SBE_CHK_W-1:0] in_chk;
   reg [4:0] state;
   reg [CNT_W-1:0] words_left;
   reg refill;
   reg [`SBE_AD_W-1:0] wdata_hold;
   reg [1:0] err_sr;
   reg [1:0] inv_sr;
   reg tout_start;
   reg tout_stop;
   wire alt_mode;
   wire rsp_word;
   wire gd_err;
   wire chk_err;
   wire last_word;
   wire tout_hit;
   wire [`SBE_CHK_W-1:0] chk_calc;

   // Strap from the pin: two flops before anything looks at it
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         mode_s1 <= 1'b1;
         mode_s2 <= 1'b1;
      end else begin
         mode_s1 <= i_protocol_select_pin;
         mode_s2 <= mode_s1;
      end
   end

   assign alt_mode = ~mode_s2;

   // Input registers; bus is register to register on the interface clock
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         in_valid_n <= 1'b1;
         in_rqst_n <= 1'b1;
         in_accept_n <= 1'b1;
         in_cmd <= {`SBE_CMD_W{1'b0}};
         in_ad <= `SBE_AD_ZERO;
         in_chk <= `SBE_CHK_ZERO;
      end else begin
         in_valid_n <= i_ext_valid_in_n;
         in_rqst_n <= i_ext_bus_rqst_n;
         in_accept_n <= i_ext_accept_ready_n;
         in_cmd <= i_sys_command_bus;
         in_ad <= i_sys_addr_data_bus;
         in_chk <= i_data_check_bits;
      end
   end

   // Even parity per byte; one check bit for each byte lane
   genvar b;
   generate
      for (b = 0; b < `SBE_CHK_W; b = b + 1) begin : g_chk
         assign chk_calc[b] = ^in_ad[b*8 +: 8];
      end
   endgenerate

   // Response word seen while a read is pending; top command bit marks data
   assign rsp_word = state[3] && !in_valid_n && in_cmd[`SBE_CMD_DATA]
      && !in_cmd[`SBE_ID_RESP];
   assign gd_err = rsp_word && in_cmd[`SBE_ID_ERR];
   // Alternate mode carries no check bits, so only native mode evaluates them
   assign chk_err = rsp_word && !alt_mode && !in_cmd[`SBE_ID_NOCHK]
      && (chk_calc != in_chk);
   // Full block is awaited even after a bad element
   assign last_word = rsp_word
      && (words_left == {{(CNT_W-1){1'b0}}, 1'b1});

   sbe_rd_timeout #(
      .CW(`SBE_TOUT_W)
   ) sbe_rd_timeout_inst (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_start(tout_start),
      .i_stop(tout_stop),
      .i_enable(i_read_timeout_enable),
      .i_native_mode(mode_s2),
      .i_period(i_read_timeout_period),
      .o_expired(tout_hit)
   );

   // Error delay line: good-data enters late so both causes meet one output
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         err_sr <= 2'h0;
         inv_sr <= 2'h0;
         o_bus_error <= 1'b0;
         o_line_invalid <= 1'b0;
      end else begin
         err_sr[0] <= chk_err;
         err_sr[1] <= err_sr[0] | gd_err;
         inv_sr[0] <= chk_err & refill;
         inv_sr[1] <= inv_sr[0] | (gd_err & refill);
         // One flag for every cause; software cannot tell them apart
         o_bus_error <= err_sr[1] | tout_hit;
         o_line_invalid <= inv_sr[1] | (tout_hit & refill);
      end
   end

   // Handshake state machine; agent request wins over a new core request
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_IDLE;
         words_left <= {CNT_W{1'b0}};
         refill <= 1'b0;
         wdata_hold <= `SBE_AD_ZERO;
         tout_start <= 1'b0;
         tout_stop <= 1'b0;
         o_req_ready <= 1'b0;
         o_rd_data <= `SBE_AD_ZERO;
         o_rd_valid <= 1'b0;
         o_rd_last <= 1'b0;
         o_sys_addr_data_bus <= `SBE_AD_ZERO;
         o_sys_addr_data_bus_oe <= 1'b0;
         o_sys_command_bus <= {`SBE_CMD_W{1'b0}};
         o_sys_command_bus_oe <= 1'b0;
         o_proc_valid_out_n <= 1'b1;
         o_proc_mastership_release_n <= 1'b1;
      end else begin
         tout_start <= 1'b0;
         tout_stop <= 1'b0;
         o_req_ready <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_last <= 1'b0;
         o_proc_valid_out_n <= 1'b1;
         case (state)
            ST_IDLE: begin
               o_sys_addr_data_bus_oe <= 1'b1;
               o_sys_command_bus_oe <= 1'b1;
               if (!in_rqst_n) begin
                  // Hand the bus over and stop driving it
                  o_proc_mastership_release_n <= 1'b0;
                  o_sys_addr_data_bus_oe <= 1'b0;
                  o_sys_command_bus_oe <= 1'b0;
                  state <= ST_EXT;
               end else if (i_req_valid && !in_accept_n && !o_req_ready) begin
                  o_req_ready <= 1'b1;
                  o_sys_addr_data_bus <= i_req_addr;
                  o_sys_command_bus <= {1'b0, i_req_cmd};
                  o_proc_valid_out_n <= 1'b0;
                  wdata_hold <= i_req_wdata;
                  words_left <= i_req_words;
                  refill <= (i_req_words > {{(CNT_W-1){1'b0}}, 1'b1});
                  if (i_req_write) begin
                     state <= ST_WADDR;
                  end else begin
                     tout_start <= 1'b1;
                     state <= ST_RWAIT;
                  end
               end
            end
            ST_WADDR: begin
               // Data cycle follows the address cycle directly
               o_sys_addr_data_bus <= wdata_hold;
               o_sys_command_bus <= {1'b1, `SBE_WR_ID};
               o_proc_valid_out_n <= 1'b0;
               state <= ST_WDATA;
            end
            ST_WDATA: begin
               state <= ST_IDLE;
            end
            ST_RWAIT: begin
               // Agent owns the bus by default while the reply is pending
               o_sys_addr_data_bus_oe <= 1'b0;
               o_sys_command_bus_oe <= 1'b0;
               o_proc_mastership_release_n <= 1'b0;
               if (rsp_word) begin
                  o_rd_data <= in_ad;
                  o_rd_valid <= 1'b1;
                  words_left <= words_left - {{(CNT_W-1){1'b0}}, 1'b1};
               end
               if (last_word || tout_hit) begin
                  o_rd_last <= last_word;
                  tout_stop <= 1'b1;
                  o_proc_mastership_release_n <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_EXT: begin
               // External requests run here; bus returns once request drops and agent valid is idle
               if (in_rqst_n && in_valid_n) begin
                  o_proc_mastership_release_n <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Legacy pins: held low in alternate mode; no protocol-error output exists
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sys_command_hi <= `SBE_HI_ZERO;
         o_data_check_bits <= `SBE_CHK_ZERO;
         o_data_check_bits_oe <= 1'b1;
         o_command_parity <= 1'b0;
         o_read_ready_n <= 1'b0;
         o_read_ready_oe <= 1'b1;
      end else begin
         o_sys_command_hi <= `SBE_HI_ZERO;
         o_command_parity <= 1'b0;
         o_read_ready_n <= 1'b0;
         o_read_ready_oe <= alt_mode;
         if (alt_mode) begin
            o_data_check_bits <= `SBE_CHK_ZERO;
            o_data_check_bits_oe <= 1'b1;
         end else begin
            // Native mode: check bits driven only with the write data word
            o_data_check_bits_oe <= (state == ST_WADDR);
            o_data_check_bits <= chk_calc_w(wdata_hold);
         end
      end
   end

   // Byte-lane parity of an outgoing word
   function [`SBE_CHK_W-1:0] chk_calc_w;
      input [`SBE_AD_W-1:0] w;
      integer k;
      begin
         for (k = 0; k < `SBE_CHK_W; k = k + 1) begin
            chk_calc_w[k] = ^w[k*8 +: 8];
         end
      end
   endfunction
endmodule // sbe_sysif

// ---- testbench/sbe_sysif_checker.sv ----
// Assertion checker for the system bus handshake and error timing
`timescale 1ns/1ps
module sbe_sysif_checker (
   input wire logic i_core_clk, // Clock
   input wire logic i_reset, // Reset
   input wire logic i_protocol_select_pin, // Strap
   input wire logic [15:0] i_read_timeout_period, // Period
   input wire logic i_read_timeout_enable, // Enable
   input wire logic i_req_write, // Write
   input wire logic [3:0] i_req_words, // Words
   input wire logic [31:0] i_req_addr, // Address
   input wire logic [31:0] i_req_wdata, // Write word
   input wire logic o_req_ready, // Taken
   input wire logic o_bus_error, // Error pulse
   input wire logic o_line_invalid, // Line invalid
   input wire logic [31:0] i_sys_addr_data_bus, // Bus in
   input wire logic [31:0] o_sys_addr_data_bus, // Bus out
   input wire logic o_sys_addr_data_bus_oe, // Bus drive
   input wire logic [4:0] i_sys_command_bus, // Cmd in
   input wire logic [4:0] o_sys_command_bus, // Cmd out
   input wire logic o_sys_command_bus_oe, // Cmd drive
   input wire logic [3:0] o_sys_command_hi, // Upper cmd
   input wire logic [3:0] i_data_check_bits, // Check in
   input wire logic [3:0] o_data_check_bits, // Check out
   input wire logic o_data_check_bits_oe, // Check drive
   input wire logic o_command_parity, // Parity
   input wire logic o_read_ready_n, // Read-ready
   input wire logic o_read_ready_oe, // Read-ready drive
   input wire logic i_ext_valid_in_n, // Agent valid
   input wire logic o_proc_valid_out_n, // Own valid
   input wire logic o_proc_mastership_release_n // Released
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   logic [1:0] up_cnt;
   // Mode-dependent outputs follow the strap only from the third edge after reset
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) up_cnt <= 2'h0;
      else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
   end
   logic blk;
   // Block refill flag, caught while the read request is taken
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) blk <= 1'b0;
      else if (o_req_ready) blk <= (i_req_words > 4'h1);
   end
   // Response words seen while the agent owns the bus
   wire alt_ok = (up_cnt == 2'h3) && !i_protocol_select_pin;
   wire resp_in = !i_ext_valid_in_n && i_sys_command_bus[4] && !i_sys_command_bus[2]
      && !o_proc_mastership_release_n;
   wire [3:0] par = {^i_sys_addr_data_bus[31:24], ^i_sys_addr_data_bus[23:16],
      ^i_sys_addr_data_bus[15:8], ^i_sys_addr_data_bus[7:0]};
   wire chk_bad = resp_in && i_protocol_select_pin && !i_sys_command_bus[0]
      && (i_data_check_bits != par);
   sequence s_addr_cyc;
      o_req_ready && !o_proc_valid_out_n && !o_sys_command_bus[4];
   endsequence
   sequence s_data_cyc;
      !o_proc_valid_out_n && o_sys_command_bus[4] && o_sys_addr_data_bus == i_req_wdata;
   endsequence
   a_hi_lines_low: assert property (o_sys_command_hi == 4'h0 && !o_command_parity)
      else $error("upper command or parity line not low");
   a_alt_chk_low: assert property (alt_ok |-> o_data_check_bits == 4'h0 && o_data_check_bits_oe)
      else $error("check lines not driven low");
   a_read_ready_n_low: assert property (alt_ok |-> !o_read_ready_n && o_read_ready_oe)
      else $error("read-ready not driven low");
   a_valid_drive: assert property (!o_proc_valid_out_n |-> o_sys_addr_data_bus_oe && o_sys_command_bus_oe)
      else $error("valid out without driven bus");
   a_write_cycles: assert property (s_addr_cyc ##0 i_req_write |->
      o_sys_addr_data_bus == i_req_addr ##1 s_data_cyc ##1 o_proc_valid_out_n)
      else $error("write cycles wrong");
   a_read_release: assert property (s_addr_cyc ##0 !i_req_write |=>
      !o_proc_mastership_release_n && !o_sys_addr_data_bus_oe)
      else $error("bus not released after read");
   a_gd_error: assert property (resp_in && i_sys_command_bus[1] |-> ##3 o_bus_error)
      else $error("bad data flag error late");
   a_chk_error: assert property (chk_bad |-> ##4 o_bus_error)
      else $error("check bit error late");
   a_line_inval: assert property (o_line_invalid |-> o_bus_error)
      else $error("line invalid without bus error");
   a_gd_inval: assert property (resp_in && i_sys_command_bus[1] && blk |-> ##3 o_line_invalid)
      else $error("refill line not invalidated");
   a_rd_timeout: assert property (s_addr_cyc ##0 (!i_req_write && alt_ok
      && i_read_timeout_enable && i_read_timeout_period == 16'h0005)
      ##1 i_ext_valid_in_n [*6] |-> ##[0:6] o_bus_error)
      else $error("read timeout missing");
endmodule // sbe_sysif_checker
bind sbe_sysif sbe_sysif_checker sbe_sysif_checker_inst (.*);

// ---- testbench/sbe_agent_model.sv ----
// External agent model answering processor reads
`timescale 1ns/1ps
module sbe_agent_model (
   input wire logic i_core_clk, // Clock
   input wire logic i_reset, // Reset
   input wire logic i_release_n, // Bus handed over
   input wire logic [3:0] i_words, // Reply length
   input wire logic [3:0] i_err_word, // Word flagged bad
   input wire logic i_bad_chk, // Corrupt check bits
   input wire logic i_silent, // Never reply
   input wire logic i_slow, // Gap between words
   output logic [31:0] o_ad, // Address/data
   output logic [4:0] o_cmd, // Command
   output wire logic [3:0] o_chk, // Check bits
   output logic o_valid_n, // Valid
   output wire logic o_accept_n, // Accept-ok
   output wire logic o_rqst_n // Bus request
);
   logic [3:0] sent;
   logic gap;
   // Never asks for the bus, always able to take a request
   assign o_rqst_n = 1'b1;
   assign o_accept_n = 1'b0;
   assign o_chk = {^o_ad[31:24], ^o_ad[23:16], ^o_ad[15:8], ^o_ad[7:0]} ^ {4{i_bad_chk}};
   // Changes after the falling edge; idle bus toggles so stale data never looks valid
   always @(negedge i_core_clk) begin
      if (i_reset) begin
         o_ad <= 32'h5A5A_5A5A;
         o_cmd <= 5'h0A;
         o_valid_n <= 1'b1;
         sent <= 4'h0;
         gap <= 1'b0;
      end else if (!i_release_n && !i_silent && sent < i_words && !gap) begin
         o_ad <= 32'hC0DE_0000 + {28'h000_0000, sent};
         o_cmd <= {1'b1, sent != i_words - 4'h1, 1'b0, sent == i_err_word, 1'b0};
         o_valid_n <= 1'b0;
         sent <= sent + 4'h1;
         gap <= i_slow;
      end else begin
         o_ad <= ~o_ad;
         o_cmd <= ~o_cmd;
         o_valid_n <= 1'b1;
         gap <= 1'b0;
         if (i_release_n) sent <= 4'h0;
      end
   end
endmodule // sbe_agent_model

// ---- testbench/sbe_sysif_tb_top.sv ----
// Self-checking bench for the system bus block
`timescale 1ns/1ps
module sbe_sysif_tb_top;
   logic clk = 1'b0, rst = 1'b1, strap = 1'b0, ten = 1'b0, rv = 1'b0, rw = 1'b0;
   logic [15:0] period = 16'h0005;
   logic [3:0] rcmd = 4'h5, rwords = 4'h1, p_err = 4'hF;
   logic [31:0] raddr = 32'h0000_0100, rwdata = 32'h0000_0000;
   logic p_bad = 1'b0, p_sil = 1'b0, p_slow = 1'b0;
   logic ready, rd_valid, berr, linv, dad_oe, dcmd_oe, dchk_oe, cpar, rrdy_n, rrdy_oe;
   logic pvn, rel_n, avn, aok_n, arq_n, rd_last;
   logic [31:0] rd_data, dad, aad;
   logic [4:0] dcmd, acmd;
   logic [3:0] chi, dchk, achk;
   logic [31:0] got[$], wcap[$];
   logic [4:0] ccap[$];
   int failures = 0, check_count = 0, errs = 0, invs = 0, cycles = 0, lasts = 0;
   wire [31:0] bus_ad = dad_oe ? dad : aad;
   wire [4:0] bus_cmd = dcmd_oe ? dcmd : acmd;
   always #25 clk = ~clk;
   sbe_sysif #(.CNT_W(4)) sbe_sysif_inst (.i_core_clk(clk), .i_reset(rst),
      .i_protocol_select_pin(strap), .i_read_timeout_period(period),
      .i_read_timeout_enable(ten), .i_req_valid(rv), .i_req_write(rw), .i_req_cmd(rcmd),
      .i_req_addr(raddr), .i_req_wdata(rwdata), .i_req_words(rwords), .o_req_ready(ready),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_last(rd_last), .o_bus_error(berr),
      .o_line_invalid(linv), .i_sys_addr_data_bus(bus_ad), .o_sys_addr_data_bus(dad),
      .o_sys_addr_data_bus_oe(dad_oe), .i_sys_command_bus(bus_cmd), .o_sys_command_bus(dcmd),
      .o_sys_command_bus_oe(dcmd_oe), .o_sys_command_hi(chi), .i_data_check_bits(achk),
      .o_data_check_bits(dchk), .o_data_check_bits_oe(dchk_oe), .o_command_parity(cpar),
      .o_read_ready_n(rrdy_n), .o_read_ready_oe(rrdy_oe), .i_ext_valid_in_n(avn),
      .o_proc_valid_out_n(pvn), .i_ext_bus_rqst_n(arq_n),
      .o_proc_mastership_release_n(rel_n), .i_ext_accept_ready_n(aok_n));
   sbe_agent_model sbe_agent_model_inst (.i_core_clk(clk), .i_reset(rst), .i_release_n(rel_n),
      .i_words(rwords), .i_err_word(p_err), .i_bad_chk(p_bad), .i_silent(p_sil),
      .i_slow(p_slow), .o_ad(aad), .o_cmd(acmd), .o_chk(achk), .o_valid_n(avn),
      .o_accept_n(aok_n), .o_rqst_n(arq_n));
   // Record reply words, error pulses and own bus cycles
   always @(posedge clk) begin
      cycles++;
      if (rd_valid) got.push_back(rd_data);
      if (berr) errs++;
      if (linv) invs++;
      if (rd_last && rd_valid) lasts++;
      if (!pvn) begin
         wcap.push_back(dad);
         ccap.push_back(dcmd);
      end
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic do_reset(input logic s);
      @(negedge clk);
      rst = 1'b1;
      strap = s;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   // Issue one request, hold it until taken, then wait for the bus to settle
   task automatic request(input logic w, input logic [3:0] n);
      int k;
      got.delete();
      wcap.delete();
      ccap.delete();
      errs = 0;
      invs = 0;
      lasts = 0;
      @(negedge clk);
      rw = w;
      rwords = n;
      rwdata = ~raddr;
      rv = 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (!ready && k < 50);
      rv = 1'b0;
      check(ready, 1'b1);
      k = 0;
      while (!(rel_n && pvn) && k < 80) begin
         @(negedge clk);
         k++;
      end
      repeat (6) @(negedge clk);
   endtask
   task automatic t_alt_pins();
      check({chi, cpar, rrdy_n, rrdy_oe}, 7'h01);
      check({dchk, dchk_oe}, 5'h01);
      $display("t_alt_pins done");
   endtask
   task automatic t_write();
      request(1'b1, 4'h1);
      check(wcap.size(), 2);
      check(wcap[0], raddr);
      check(wcap[1], ~raddr);
      check(ccap[0], {1'b0, rcmd});
      check(ccap[1], 5'h14);
      $display("t_write done");
   endtask
   task automatic t_refill_err();
      p_err = 4'h2;
      p_slow = 1'b1;
      request(1'b0, 4'h4);
      check(got.size(), 4);
      for (int i = 0; i < 4; i++) check(got[i], 32'hC0DE_0000 + i);
      check(errs, 1);
      check(invs, 1);
      check(lasts, 1);
      p_err = 4'hF;
      p_slow = 1'b0;
      $display("t_refill_err done");
   endtask
   task automatic t_timeout();
      ten = 1'b1;
      p_sil = 1'b1;
      request(1'b0, 4'h1);
      check(errs, 1);
      check(got.size(), 0);
      check(lasts, 0);
      p_sil = 1'b0;
      request(1'b0, 4'h1);
      check(got.size(), 1);
      check(errs, 0);
      $display("t_timeout done");
   endtask
   task automatic t_native_chk();
      do_reset(1'b1);
      check(rrdy_oe, 1'b0);
      // Silent agent in native mode: the timeout must stay quiet
      p_sil = 1'b1;
      request(1'b0, 4'h1);
      check(errs, 0);
      check(got.size(), 0);
      p_sil = 1'b0;
      repeat (8) @(negedge clk);
      p_bad = 1'b1;
      request(1'b0, 4'h1);
      check(errs, 1);
      p_bad = 1'b0;
      request(1'b0, 4'h1);
      check(errs, 0);
      check(got[0], 32'hC0DE_0000);
      $display("t_native_chk done");
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      t_alt_pins();
      t_write();
      t_refill_err();
      t_timeout();
      t_native_chk();
      wrap_up();
   end
endmodule // sbe_sysif_tb_top
